// *** hw/deser_lane_map_eq_ssc_config.sv ***
/*
  Deserializer output side: samples the recovered pixel word and pixel clock,
  gains lock, maps pixels onto four seven-bit lanes, and holds the equalizer and
  spread-spectrum configuration with pin or register control.
  Assumes pixel data changes on the falling pixel clock edge and that the local
  register port is driven synchronously to clk.
*/
// Contract
// (R1) Boost field bits 7:5 picks eight gain steps, 1.625 dB to 13 dB.
// (R2) Equalization acts only while equalizer_on bit 4 is set.
// (R3) Normal range: profile codes give listed deviations at clock/2168 or clock/1300.
// (R4) Low range: profile codes give listed deviations at clock/625 or clock/385.
// (R5) Carry 24 color bits plus sync and data window at 5 to 65 MHz; the code samples the pixel clock at 50 MHz, so only below 25 MHz.
// (R6) In 18-bit use, spare color positions carry general purpose signals.
// (R7) Serial identifier is captured while power_down_n is held low.
// (R8) Lock to any active data stream without training patterns.
// (R9) Lane 3 and lane 2 carry the default low color and control bits.
// (R10) Lane 1 and lane 0 carry the default mid color bits.
// (R11) Legacy mode puts inputs 0 to 20 on bits 0 to 20 only.
// (R12) Compat select: plain, filtered controls, or two legacy modes.
// (R13) Override bit chooses registers over pins, except the identifier; the code also keeps range select on its pin.
// (R14) Range select is an input, switching only while spreading is off.
`timescale 1ns/100ps
module deser_lane_map_eq_ssc_config
  import deser_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Pins from the link and straps
  input  wire logic        power_down_n,
  input  wire logic        pclk_pin,
  input  wire pixel_s      pixel_pin,
  input  wire logic [6:0]  id_strap_pin,
  input  wire cfg_s        cfg_pin,
  // Local register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic [7:0]       reg_rdata,
  output logic             reg_rvalid,
  // Lanes
  output logic [6:0]       lane0_output,
  output logic [6:0]       lane1_output,
  output logic [6:0]       lane2_output,
  output logic [6:0]       lane3_output,
  output logic             lane_clock_output,
  output logic             link_locked,
  // Equalizer and spread state
  output logic             equalizer_on,
  output logic [2:0]       equalizer_boost_step,
  output logic [6:0]       equalizer_boost_step_eighth_db,
  output logic             spread_active,
  output logic [7:0]       spread_deviation,
  output logic [11:0]      spread_divisor,
  output logic             spread_mod_up,
  output logic [6:0]       slave_id
);

  localparam int SYNC_W = 2 + $bits(pixel_s) + 7 + $bits(cfg_s);

  // Pin synchronizer, stage a is read only by stage b
  logic [SYNC_W-1:0] sync_a_reg, sync_b_reg;
  logic              pd_n_s, pclk_s, pclk_prev_reg;
  pixel_s            pixel_s_w;
  logic [6:0]        strap_s;
  cfg_s              cfg_s_w;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a_reg    <= '0;
      sync_b_reg    <= '0;
      pclk_prev_reg <= 1'b0;
    end else begin
      sync_a_reg    <= {power_down_n, pclk_pin, pixel_pin, id_strap_pin, cfg_pin};
      sync_b_reg    <= sync_a_reg;
      pclk_prev_reg <= pclk_s;
    end
  end

  assign {pd_n_s, pclk_s, pixel_s_w, strap_s, cfg_s_w} = sync_b_reg;

  logic pclk_rise;
  assign pclk_rise = pclk_s & ~pclk_prev_reg;

  // Register file
  logic [7:0] general_reg, general_next;
  logic [7:0] features_reg, features_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;
  logic [6:0] id_reg, id_next;

  always_comb begin
    general_next  = general_reg;
    features_next = features_reg;
    if (reg_write && reg_addr == GENERAL_CONFIG_OFFSET) begin
      general_next = reg_wdata & GENERAL_CONFIG_MASK;
    end
    if (reg_write && reg_addr == EQ_SSC_FEATURES_OFFSET) begin
      features_next = reg_wdata & EQ_SSC_FEATURES_MASK;
    end
    rvalid_next = reg_read;
    rdata_next  = 8'h00;
    if (reg_read && reg_addr == GENERAL_CONFIG_OFFSET) begin
      rdata_next = general_reg;
    end else if (reg_read && reg_addr == EQ_SSC_FEATURES_OFFSET) begin
      rdata_next = features_reg;
    end
    // Identifier follows the straps only while held in power down
    id_next = pd_n_s ? id_reg : strap_s; // see (R7)
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      general_reg  <= GENERAL_CONFIG_RESET;
      features_reg <= EQ_SSC_FEATURES_RESET;
      rdata_reg    <= 8'h00;
      rvalid_reg   <= 1'b0;
      id_reg       <= SLAVE_ID_RESET;
    end else begin
      general_reg  <= general_next;
      features_reg <= features_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
      id_reg       <= id_next;
    end
  end

  // Effective configuration; range select always comes from its pin
  cfg_s cfg_eff;
  always_comb begin
    cfg_eff = cfg_s_w; // see (R13)
    if (general_reg[OVERRIDE_BIT]) begin
      cfg_eff.compat  = compat_e'(general_reg[COMPAT_LSB +: 2]); // see (R13)
      cfg_eff.eq_on   = features_reg[EQ_ON_BIT];
      cfg_eff.eq_step = features_reg[EQ_STEP_LSB +: 3];
      cfg_eff.profile = features_reg[PROFILE_LSB +: 3];
    end
  end

  // Lock tracking: any steady stream of pixel edges locks, no pattern needed
  lock_state_e lock_reg, lock_next;
  logic [7:0]  gap_reg, gap_next;
  logic [4:0]  edges_reg, edges_next;

  always_comb begin
    lock_next  = lock_reg;
    edges_next = edges_reg;
    gap_next   = pclk_rise ? 8'h00 : ((gap_reg == 8'hFF) ? gap_reg : gap_reg + 8'h01);
    case (lock_reg)
      LOCK_HUNT: begin
        if (pclk_rise) begin
          if (edges_reg == 5'(LOCK_EDGES - 1)) begin
            lock_next  = LOCK_HELD; // see (R8)
            edges_next = 5'h00;
          end else begin
            edges_next = edges_reg + 5'h01;
          end
        end
        if (gap_reg >= 8'(LOCK_GAP_CYCLES)) begin
          edges_next = 5'h00;
        end
      end
      LOCK_HELD: begin
        if (gap_reg >= 8'(LOCK_GAP_CYCLES)) begin
          lock_next = LOCK_HUNT;
        end
      end
      default: lock_next = LOCK_HUNT;
    endcase
    if (!pd_n_s) begin
      lock_next  = LOCK_HUNT;
      edges_next = 5'h00;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_reg  <= LOCK_HUNT;
      gap_reg   <= 8'h00;
      edges_reg <= 5'h00;
    end else begin
      lock_reg  <= lock_next;
      gap_reg   <= gap_next;
      edges_reg <= edges_next;
    end
  end

  // Pixel mapping onto the lanes
  logic [WORD_BITS-1:0] lanes_reg, lanes_next;
  logic                 strobe_reg, strobe_next;
  logic [2:0]           ctrl_prev_reg, ctrl_prev_next;
  logic [2:0]           ctrl_kept_reg, ctrl_kept_next;
  logic [23:0]          din;
  logic [2:0]           ctrl_raw, ctrl_use;
  logic                 pixel_tick;

  assign pixel_tick = pclk_rise & (lock_reg == LOCK_HELD);
  assign din        = {pixel_s_w.blue, pixel_s_w.green, pixel_s_w.red};
  assign ctrl_raw   = {pixel_s_w.de, pixel_s_w.vs, pixel_s_w.hs};

  always_comb begin
    ctrl_prev_next = ctrl_prev_reg;
    ctrl_kept_next = ctrl_kept_reg;
    lanes_next     = lanes_reg;
    strobe_next    = pixel_tick;
    ctrl_use       = ctrl_raw; // see (R12)
    if (cfg_eff.compat == COMPAT_FILTERED && ctrl_raw != ctrl_prev_reg) begin
      // A control change must repeat on two pixels, trading one pixel of delay for glitch immunity
      ctrl_use = ctrl_kept_reg; // see (R12)
    end
    if (pixel_tick) begin
      ctrl_prev_next = ctrl_raw;
      ctrl_kept_next = ctrl_use;
      case (cfg_eff.compat)
        COMPAT_LEGACY_A, COMPAT_LEGACY_B: begin
          lanes_next = {7'h00, din[LEGACY_BITS-1:0]}; // see (R11)
        end
        default: begin
          // Spare low color bits pass untouched, so they can serve as general purpose signals
          lanes_next = {1'b0,
                        pixel_s_w.blue[1:0], pixel_s_w.green[1:0], pixel_s_w.red[1:0], // see (R9)
                        ctrl_use, pixel_s_w.blue[7:4],                                  // see (R9)
                        pixel_s_w.blue[3:2], pixel_s_w.green[7:3],                      // see (R10)
                        pixel_s_w.green[2], pixel_s_w.red[7:2]};                        // see (R10) see (R5) see (R6)
        end
      endcase
    end
    if (lock_reg != LOCK_HELD) begin
      lanes_next = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lanes_reg     <= '0;
      strobe_reg    <= 1'b0;
      ctrl_prev_reg <= 3'h0;
      ctrl_kept_reg <= 3'h0;
    end else begin
      lanes_reg     <= lanes_next;
      strobe_reg    <= strobe_next;
      ctrl_prev_reg <= ctrl_prev_next;
      ctrl_kept_reg <= ctrl_kept_next;
    end
  end

  // Equalizer controls
  logic       eq_on_reg, eq_on_next;
  logic [2:0] eq_step_reg, eq_step_next;
  logic [6:0] equalizer_boost_step_reg, equalizer_boost_step_next;

  always_comb begin
    eq_on_next   = cfg_eff.eq_on;
    eq_step_next = cfg_eff.eq_step; // see (R1)
    equalizer_boost_step_next = 7'h00; // see (R2)
    if (cfg_eff.eq_on) begin
      equalizer_boost_step_next = 7'(EQ_STEP_EIGHTH_DB * ({4'h0, cfg_eff.eq_step} + 7'h01)); // see (R1)
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eq_on_reg   <= 1'b0;
      eq_step_reg <= 3'h0;
      equalizer_boost_step_reg <= 7'h00;
    end else begin
      eq_on_reg   <= eq_on_next;
      eq_step_reg <= eq_step_next;
      equalizer_boost_step_reg <= equalizer_boost_step_next;
    end
  end

  spread_clock_generator spread_gen (
    .clk           (clk),
    .rst           (rst),
    .pixel_tick    (pixel_tick),
    .profile       (cfg_eff.profile),
    .lf_range_req  (cfg_eff.lf_range),
    .spread_active (spread_active),
    .deviation     (spread_deviation),
    .divisor       (spread_divisor),
    .mod_up        (spread_mod_up)
  );

  assign reg_rdata            = rdata_reg;
  assign reg_rvalid           = rvalid_reg;
  assign lane0_output         = lanes_reg[6:0];
  assign lane1_output         = lanes_reg[13:7];
  assign lane2_output         = lanes_reg[20:14];
  assign lane3_output         = lanes_reg[27:21];
  assign lane_clock_output    = strobe_reg;
  assign link_locked          = (lock_reg == LOCK_HELD);
  assign equalizer_on         = eq_on_reg;
  assign equalizer_boost_step = eq_step_reg;
  assign equalizer_boost_step_eighth_db    = equalizer_boost_step_reg;
  assign slave_id             = id_reg;

endmodule : deser_lane_map_eq_ssc_config

// *** hw/deser_cfg_pkg.sv ***
/*
  Shared constants and types for the pixel deserializer lane mapper,
  equalizer and spread-spectrum configuration block.
  Assumes a 50 MHz system clock and a byte-wide local register port.
*/
package deser_cfg_pkg;

  // Clock and timing
  localparam int CLK_FREQ_MHZ    = 50;
  localparam int LOCK_GAP_NS     = 2000;
  localparam int LOCK_GAP_CYCLES = (LOCK_GAP_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int LOCK_EDGES      = 16;

  // Lane geometry
  localparam int LANE_BITS = 7;
  localparam int LANES     = 4;
  localparam int WORD_BITS = LANE_BITS * LANES;
  localparam int LEGACY_BITS = 21;

  // Register offsets
  localparam logic [7:0] GENERAL_CONFIG_OFFSET  = 8'h00;
  localparam logic [7:0] EQ_SSC_FEATURES_OFFSET = 8'h03;

  // Field positions
  localparam int OVERRIDE_BIT = 0;
  localparam int COMPAT_LSB   = 2;
  localparam int PROFILE_LSB  = 0;
  localparam int EQ_ON_BIT    = 4;
  localparam int EQ_STEP_LSB  = 5;

  // Reset values and writable masks
  localparam logic [7:0] GENERAL_CONFIG_RESET  = 8'h00;
  localparam logic [7:0] EQ_SSC_FEATURES_RESET = 8'h00;
  localparam logic [7:0] GENERAL_CONFIG_MASK   = 8'h0D;
  localparam logic [7:0] EQ_SSC_FEATURES_MASK  = 8'hF7;

  // Equalizer step size, 1.625 dB in eighths of a dB
  localparam logic [6:0] EQ_STEP_EIGHTH_DB = 7'h0D;

  // Arbitrary neutral reset value for the captured serial bus identifier
  localparam logic [6:0] SLAVE_ID_RESET = 7'h00;

  typedef enum logic [1:0] {
    COMPAT_PLAIN,
    COMPAT_FILTERED,
    COMPAT_LEGACY_A,
    COMPAT_LEGACY_B
  } compat_e;

  typedef enum logic {
    LOCK_HUNT,
    LOCK_HELD
  } lock_state_e;

  typedef struct packed {
    compat_e    compat;
    logic       eq_on;
    logic [2:0] eq_step;
    logic [2:0] profile;
    logic       lf_range;
  } cfg_s;

  typedef struct packed {
    logic       de;
    logic       vs;
    logic       hs;
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
  } pixel_s;

endpackage : deser_cfg_pkg

// *** hw/spread_clock_generator.sv ***
/*
  Spread-spectrum profile selector and triangle modulation phase counter.
  Assumes pixel_tick is a one-cycle pulse per recovered pixel in the clk domain.
*/
`timescale 1ns/100ps
module spread_clock_generator
  import deser_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        pixel_tick,
  input  wire logic [2:0]  profile,
  input  wire logic        lf_range_req,
  // Profile state
  output logic             spread_active,
  output logic [7:0]       deviation,
  output logic [11:0]      divisor,
  output logic             mod_up
);

  logic        lf_reg,     lf_next;
  logic [10:0] phase_reg,  phase_next;
  logic        up_reg,     up_next;
  logic        active_next;
  logic [7:0]  dev_next;
  logic [11:0] div_next;
  logic        active_reg;
  logic [7:0]  dev_reg;
  logic [11:0] div_reg;

  always_comb begin
    // Range changes only with spreading off, so a live profile never jumps tables
    lf_next = (profile == 3'h0) ? lf_range_req : lf_reg; // see (R14)
    active_next = (profile != 3'h0);
    dev_next = 8'h00;
    div_next = 12'h000;
    case ({lf_reg, profile})
      4'h1: begin dev_next = 8'h5A; div_next = 12'h878; end // see (R3)
      4'h2: begin dev_next = 8'h78; div_next = 12'h878; end
      4'h3: begin dev_next = 8'hBE; div_next = 12'h878; end
      4'h4: begin dev_next = 8'hE6; div_next = 12'h878; end
      4'h5: begin dev_next = 8'h46; div_next = 12'h514; end
      4'h6: begin dev_next = 8'h82; div_next = 12'h514; end
      4'h7: begin dev_next = 8'h9D; div_next = 12'h514; end
      4'h9: begin dev_next = 8'h46; div_next = 12'h271; end // see (R4)
      4'hA: begin dev_next = 8'h82; div_next = 12'h271; end
      4'hB: begin dev_next = 8'hB4; div_next = 12'h271; end
      4'hC: begin dev_next = 8'hDC; div_next = 12'h271; end
      4'hD: begin dev_next = 8'h46; div_next = 12'h271; end
      4'hE: begin dev_next = 8'h78; div_next = 12'h181; end
      4'hF: begin dev_next = 8'hAA; div_next = 12'h181; end
      default: begin dev_next = 8'h00; div_next = 12'h000; end
    endcase
    phase_next = phase_reg;
    up_next = up_reg;
    if (!active_next) begin
      phase_next = 11'h000;
      up_next = 1'b1;
    end else if (pixel_tick) begin
      // Half the modulation period per slope gives a triangle at pixel/divisor
      if (phase_reg >= div_next[11:1] - 11'h001) begin
        phase_next = 11'h000;
        up_next = ~up_reg;
      end else begin
        phase_next = phase_reg + 11'h001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lf_reg     <= 1'b0;
      phase_reg  <= 11'h000;
      up_reg     <= 1'b1;
      active_reg <= 1'b0;
      dev_reg    <= 8'h00;
      div_reg    <= 12'h000;
    end else begin
      lf_reg     <= lf_next;
      phase_reg  <= phase_next;
      up_reg     <= up_next;
      active_reg <= active_next;
      dev_reg    <= dev_next;
      div_reg    <= div_next;
    end
  end

  assign spread_active = active_reg;
  assign deviation     = dev_reg;
  assign divisor       = div_reg;
  assign mod_up        = up_reg;

endmodule : spread_clock_generator

// *** dv/deser_cfg_monitor.sv ***
/*
  Checker for the lane mapper, equalizer and spread configuration block.
  Sees only the top module ports and is attached by the bind below.
*/
`timescale 1ns/100ps
module deser_cfg_monitor
  import deser_cfg_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Pins and register port
  input wire logic        power_down_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        reg_rvalid,
  // Lanes
  input wire logic [6:0]  lane0_output,
  input wire logic [6:0]  lane1_output,
  input wire logic [6:0]  lane2_output,
  input wire logic [6:0]  lane3_output,
  input wire logic        lane_clock_output,
  input wire logic        link_locked,
  // Equalizer and spread state
  input wire logic        equalizer_on,
  input wire logic [2:0]  equalizer_boost_step,
  input wire logic [6:0]  equalizer_boost_step_eighth_db,
  input wire logic        spread_active,
  input wire logic [7:0]  spread_deviation,
  input wire logic [11:0] spread_divisor,
  input wire logic [6:0]  slave_id
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_read_answered: assert property (reg_read |=> reg_rvalid) else $error("read got no answer");
  a_answer_asked: assert property (!reg_read |=> !reg_rvalid) else $error("answer without read");
  a_unmapped_zero: assert property (reg_read && reg_addr != 8'h00 && reg_addr != 8'h03 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_eq_bypass: assert property (!equalizer_on |-> equalizer_boost_step_eighth_db == 7'h00) else $error("gain while off");
  a_equalizer_boost_step_step: assert property (equalizer_on |->
    equalizer_boost_step_eighth_db == 7'(13 * (equalizer_boost_step + 1))) else $error("gain step wrong");
  a_spread_rates: assert property (spread_active |->
    spread_divisor inside {12'h878, 12'h514, 12'h271, 12'h181}) else $error("bad modulation rate");
  a_normal_devs: assert property (spread_active && spread_divisor == 12'h878 |->
    spread_deviation inside {8'h5A, 8'h78, 8'hBE, 8'hE6}) else $error("bad normal deviation");
  a_low_devs: assert property (spread_active && spread_divisor == 12'h181 |->
    spread_deviation inside {8'h78, 8'hAA}) else $error("bad low deviation");
  a_lane_pulse: assert property (lane_clock_output |=> !lane_clock_output) else $error("lane clock too long");
  a_pixel_locked: assert property (lane_clock_output |-> $past(link_locked)) else $error("pixel before lock");
  a_idle_lanes: assert property (!link_locked && !$past(link_locked) |->
    {lane3_output, lane2_output, lane1_output, lane0_output} == 28'h0) else $error("lanes busy unlocked");
  a_top_bit_zero: assert property (lane3_output[6] == 1'b0) else $error("unused lane bit set");
  a_id_frozen: assert property (power_down_n [*6] |=> $stable(slave_id)) else $error("identifier moved");

  cover property (lane_clock_output && link_locked);
  cover property (spread_active && spread_divisor == 12'h181);
  cover property (reg_rvalid && reg_rdata == 8'hF7);
endmodule : deser_cfg_monitor

bind deser_lane_map_eq_ssc_config deser_cfg_monitor i_deser_cfg_monitor (
  .clk(clk), .rst(rst), .power_down_n(power_down_n), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lane0_output(lane0_output), .lane1_output(lane1_output),
  .lane2_output(lane2_output), .lane3_output(lane3_output), .lane_clock_output(lane_clock_output),
  .link_locked(link_locked), .equalizer_on(equalizer_on), .equalizer_boost_step(equalizer_boost_step),
  .equalizer_boost_step_eighth_db(equalizer_boost_step_eighth_db), .spread_active(spread_active), .spread_deviation(spread_deviation),
  .spread_divisor(spread_divisor), .slave_id(slave_id));

// *** dv/lane_panel_model.sv ***
/*
  Display panel model: collects the four lane words on each lane clock pulse.
  Assumes the lanes are settled in the cycle that the lane clock pulses.
*/
`timescale 1ns/100ps
module lane_panel_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Lanes from the block
  input  wire logic [6:0]  lane0_output,
  input  wire logic [6:0]  lane1_output,
  input  wire logic [6:0]  lane2_output,
  input  wire logic [6:0]  lane3_output,
  input  wire logic        lane_clock_output,
  // Reassembled word
  output logic [27:0]      word_seen,
  output logic             word_strobe
);
  // Lane k holds word bits 7k+6..7k, so the highest lane comes first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_seen <= 28'h0;
      word_strobe <= 1'b0;
    end else begin
      word_strobe <= lane_clock_output;
      if (lane_clock_output)
        word_seen <= {lane3_output, lane2_output, lane1_output, lane0_output};
    end
  end
endmodule : lane_panel_model

// *** dv/deser_lane_map_eq_ssc_config_test.sv ***
/*
  Self-checking bench for the lane mapper, equalizer and spread block.
  Assumes the monitor is bound in and the panel model watches the lanes.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module deser_lane_map_eq_ssc_config_test import deser_cfg_pkg::*;;
  localparam logic [11:0] DIV_T [2][7] = '{'{12'h878, 12'h878, 12'h878, 12'h878, 12'h514, 12'h514, 12'h514},
                                           '{12'h271, 12'h271, 12'h271, 12'h271, 12'h271, 12'h181, 12'h181}};
  localparam logic [7:0]  DEV_T [2][7] = '{'{8'h5A, 8'h78, 8'hBE, 8'hE6, 8'h46, 8'h82, 8'h9D},
                                           '{8'h46, 8'h82, 8'hB4, 8'hDC, 8'h46, 8'h78, 8'hAA}};
  logic clk, rst, power_down_n, pclk_pin, reg_write, reg_read, reg_rvalid, watch, legacy, filt;
  logic lane_clock_output, link_locked, equalizer_on, spread_active, spread_mod_up, panel_strobe;
  pixel_s      pixel_pin, px;
  cfg_s        cfg_pin;
  logic [6:0]  id_strap_pin, lane0_output, lane1_output, lane2_output, lane3_output, equalizer_boost_step_eighth_db, slave_id;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, spread_deviation, re;
  logic [2:0]  equalizer_boost_step, fp, fk;
  logic [11:0] spread_divisor;
  logic [27:0] panel_word, pe;
  logic [7:0]  rq [$];
  logic [27:0] pq [$];
  int          errors, compares, cyc, seed;

  deser_lane_map_eq_ssc_config i_deser_lane_map_eq_ssc_config (
    .clk(clk), .rst(rst), .power_down_n(power_down_n), .pclk_pin(pclk_pin), .pixel_pin(pixel_pin),
    .id_strap_pin(id_strap_pin), .cfg_pin(cfg_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .lane0_output(lane0_output), .lane1_output(lane1_output), .lane2_output(lane2_output),
    .lane3_output(lane3_output), .lane_clock_output(lane_clock_output), .link_locked(link_locked),
    .equalizer_on(equalizer_on), .equalizer_boost_step(equalizer_boost_step),
    .equalizer_boost_step_eighth_db(equalizer_boost_step_eighth_db), .spread_active(spread_active), .spread_deviation(spread_deviation),
    .spread_divisor(spread_divisor), .spread_mod_up(spread_mod_up), .slave_id(slave_id));

  lane_panel_model i_lane_panel_model (
    .clk(clk), .rst(rst), .lane0_output(lane0_output), .lane1_output(lane1_output),
    .lane2_output(lane2_output), .lane3_output(lane3_output), .lane_clock_output(lane_clock_output),
    .word_seen(panel_word), .word_strobe(panel_strobe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [27:0] map_word(pixel_s p, logic leg);
    logic [23:0] din;
    din = {p.blue, p.green, p.red};
    if (leg)
      return {7'h00, din[20:0]};
    return {1'b0, p.blue[1:0], p.green[1:0], p.red[1:0], p.de, p.vs, p.hs, p.blue[7:4],
            p.blue[3:2], p.green[7:3], p.green[2], p.red[7:2]};
  endfunction : map_word

  task automatic final_report();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(logic [7:0] a, logic [7:0] ex);
    rq.push_back(ex);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
  endtask : reg_rd

  // Data changes at the falling pixel clock edge, half a period before it is taken
  task automatic send(pixel_s p);
    @(posedge clk);
    pclk_pin <= 1'b0;
    pixel_pin <= p;
    tick(3);
    @(posedge clk);
    pclk_pin <= 1'b1;
    if (watch) begin
      // Filtered controls take the raw value only once it repeats
      fk = (!filt || {p.de, p.vs, p.hs} == fp) ? {p.de, p.vs, p.hs} : fk;
      fp = {p.de, p.vs, p.hs};
      {p.de, p.vs, p.hs} = fk;
      pq.push_back(map_word(p, legacy));
    end
    tick(3);
  endtask : send

  // Early pixels acquire lock and absorb mode changes, so only later ones are noted
  task automatic run_pixels(logic leg, string nm);
    legacy = leg;
    for (int i = 0; i < 30; i++) begin
      if (i == 18) begin
        tick(4);
        `CHK("locked", 1'b1, link_locked)
        watch = 1'b1;
        {fp, fk} = 6'h00;
      end
      px = pixel_s'(27'($random(seed)));
      if (filt && i < 19)
        {px.de, px.vs, px.hs} = 3'h0;
      send(px);
    end
    tick(8);
    `CHK("pixels left", 0, pq.size())
    watch = 1'b0;
    $display("test %s done", nm);
  endtask : run_pixels

  always @(negedge clk) begin
    if (reg_rvalid === 1'b1) begin
      re = (rq.size() > 0) ? rq.pop_front() : 8'hXX;
      `CHK("reg_rdata", re, reg_rdata)
    end
    if (panel_strobe === 1'b1 && watch) begin
      pe = (pq.size() > 0) ? pq.pop_front() : 28'hXXXXXXX;
      `CHK("lane word", pe, panel_word)
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      $display("ERROR timeout expected done seen running");
      final_report();
    end
  end

  initial begin
    {rst, power_down_n, pclk_pin, reg_write, reg_read, watch, legacy, filt} = 8'h80;
    pixel_pin = '0;
    cfg_pin = '0;
    id_strap_pin = 7'h5A;
    {reg_addr, reg_wdata} = 16'h0000;
    {errors, compares, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd40};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h03, 8'h00);
    `CHK("slave_id", 7'h5A, slave_id)
    power_down_n <= 1'b1;
    tick(4);
    id_strap_pin <= 7'h13;
    tick(8);
    `CHK("slave_id held", 7'h5A, slave_id)
    reg_wr(8'h03, 8'hFF);
    reg_rd(8'h03, 8'hF7);
    reg_wr(8'h00, 8'hFF);
    reg_rd(8'h00, 8'h0D);
    reg_wr(8'h55, 8'hAA);
    reg_rd(8'h55, 8'h00);
    $display("test registers done");
    reg_wr(8'h00, 8'h01);
    for (int s = 0; s < 8; s++) begin
      reg_wr(8'h03, {3'(s), 5'h10});
      tick(3);
      `CHK("boost step", 3'(s), equalizer_boost_step)
      `CHK("gain", 7'(13 * (s + 1)), equalizer_boost_step_eighth_db)
    end
    reg_wr(8'h03, 8'hA0);
    tick(3);
    `CHK("eq off", 1'b0, equalizer_on)
    `CHK("gain off", 7'h00, equalizer_boost_step_eighth_db)
    cfg_pin.eq_on <= 1'b1;
    cfg_pin.eq_step <= 3'h2;
    reg_wr(8'h00, 8'h00);
    tick(6);
    `CHK("pin gain", 7'h27, equalizer_boost_step_eighth_db)
    reg_wr(8'h00, 8'h01);
    tick(3);
    `CHK("reg step", 3'h5, equalizer_boost_step)
    $display("test equalizer done");
    for (int lf = 0; lf < 2; lf++) begin
      reg_wr(8'h03, 8'h00);
      cfg_pin.lf_range <= 1'(lf);
      tick(8);
      for (int c = 1; c < 8; c++) begin
        reg_wr(8'h03, {5'h00, 3'(c)});
        tick(3);
        `CHK("spread on", 1'b1, spread_active)
        `CHK("divisor", DIV_T[lf][c-1], spread_divisor)
        `CHK("deviation", DEV_T[lf][c-1], spread_deviation)
      end
    end
    cfg_pin.lf_range <= 1'b0;
    tick(8);
    `CHK("range held", 12'h181, spread_divisor)
    reg_wr(8'h03, 8'h00);
    tick(3);
    `CHK("spread off", 1'b0, spread_active)
    `CHK("mod idle", 1'b1, spread_mod_up)
    $display("test spread done");
    run_pixels(1'b0, "default map");
    filt = 1'b1;
    reg_wr(8'h00, 8'h05);
    run_pixels(1'b0, "filtered");
    filt = 1'b0;
    tick(120);
    `CHK("gap unlock", 1'b0, link_locked)
    `CHK("idle lanes", 28'h0, {lane3_output, lane2_output, lane1_output, lane0_output})
    reg_wr(8'h00, 8'h09);
    run_pixels(1'b1, "legacy a");
    cfg_pin.compat <= COMPAT_LEGACY_B;
    reg_wr(8'h00, 8'h00);
    run_pixels(1'b1, "legacy b");
    power_down_n <= 1'b0;
    tick(6);
    `CHK("power down unlock", 1'b0, link_locked)
    `CHK("slave_id new", 7'h13, slave_id)
    $display("test power down done");
    final_report();
  end
endmodule : deser_lane_map_eq_ssc_config_test
